// *** ppcs_regs.sv ***
`timescale 1ns/100ps
// Functional notes
// R01: partner ability reads pause bit10, 100F bit8, 100H bit7, 10F bit6, 10H bit5.
// R02: those bits equal port status bits 4..0 respectively.
// R03: cable result in bits 14-13: normal, open, short, failed.
// R04: writing one to bit 12 starts diagnostic; hardware clears it when done.
// R05: bit 12 zero means results are valid; software waits for it.
// R06: nine-bit fault count in bits 8-0, distance about count times 0.4 m.
// R07: special control bit 11 forces link pass.
// R08: special control bit 9 loops cable receive back to cable transmit.
// R09: port control bit 15 drives all four LEDs high.
// R10: port control bit 14 disables the transmitter.
// R11: writing one to port control bit 13 restarts auto-negotiation.
// R12: port control bit 10 disables automatic crossover.
// R13: with crossover auto off, bit 9 forces crossed mode.
// R14: bit 7 enables auto-negotiation, default one; else bits 6,5 decide.
// R15: negotiation off: bit 6 one gives 100, zero gives 10.
// R16: bit 5 selects full duplex when negotiation off or failed.
// R17: bits aliased with basic control share storage, visible both ways.
// R18: read-only and reserved bits ignore writes; unsupported partner bits read zero.
module ppcs_regs (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [4:0] partner_abil, // pause,100f,100h,10f,10h from negotiation
  input wire logic an_done, // negotiation complete
  input wire logic an_failed, // negotiation failed
  input wire logic link_good, // link status from transceiver
  input wire logic diag_done, // one-cycle pulse: cable test finished
  input wire logic [1:0] diag_result, // cable test outcome
  input wire logic [8:0] diag_fault_count, // cable fault distance count
  input wire logic [3:0] led_in, // led levels from port logic
  output logic [3:0] port_led_out, // led pins
  output logic diag_start, // one-cycle pulse to start cable test
  output logic force_link, // force link pass
  output logic remote_loop, // cable receive to cable transmit loopback
  output logic tx_disable, // transmitter off
  output logic an_restart, // one-cycle pulse to restart negotiation
  output logic an_enable, // negotiation enabled
  output logic auto_cross_en, // automatic crossover on
  output logic force_cross, // force crossed mode
  output logic speed_100, // 100 when forced, else 10
  output logic full_duplex, // forced duplex in use
  output logic irq // level interrupt
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pctrl;
    logic diag_en;
    logic [1:0] result;
    logic [8:0] count;
    logic force_link;
    logic rloop;
    logic [ppcs_pkg::IRQ_W-1:0] ists;
    logic [ppcs_pkg::IRQ_W-1:0] imask;
    logic an_done_q;
    logic link_q;
    logic [3:0] leds;
    logic diag_start;
    logic an_restart;
    logic an_enable;
    logic auto_cross_en;
    logic force_cross;
    logic speed_100;
    logic full_duplex;
    logic tx_disable;
    logic irq;
  } ppcs_state_t;

  ppcs_state_t st;
  ppcs_state_t next_st;

  // ------------------------------------------------------------
  // register views
  // ------------------------------------------------------------
  logic [15:0] lpa_view;
  logic [15:0] diag_view;
  logic [15:0] basic_view;
  logic [15:0] status_view;
  logic [9:0] word_idx;
  logic wr_acc;
  logic rd_acc;
  logic hit;

  always_comb begin
    word_idx = paddr[11:2];
    wr_acc = psel && penable && pwrite && !st.pready;
    rd_acc = psel && penable && !pwrite && !st.pready;
    lpa_view = 16'h0000; // unsupported partner bits stay zero [R18]
    lpa_view[ppcs_pkg::LPA_PAUSE] = partner_abil[4]; // [R01]
    lpa_view[ppcs_pkg::LPA_100F] = partner_abil[3];
    lpa_view[ppcs_pkg::LPA_100H] = partner_abil[2];
    lpa_view[ppcs_pkg::LPA_10F] = partner_abil[1];
    lpa_view[ppcs_pkg::LPA_10H] = partner_abil[0];
    lpa_view[4:0] = ppcs_pkg::LPA_SELECTOR;
    diag_view = 16'h0000;
    diag_view[ppcs_pkg::DG_RES_HI:ppcs_pkg::DG_RES_LO] = st.result; // [R03]
    diag_view[ppcs_pkg::DG_EN] = st.diag_en; // [R05]
    diag_view[ppcs_pkg::DG_FORCE_LINK] = st.force_link;
    diag_view[ppcs_pkg::DG_RLOOP] = st.rloop;
    diag_view[ppcs_pkg::DG_CNT_HI:0] = st.count; // [R06]
    // same flops seen through the basic control layout [R17]
    basic_view = 16'h0000;
    basic_view[ppcs_pkg::BC_SPEED] = st.pctrl[ppcs_pkg::PC_SPEED];
    basic_view[ppcs_pkg::BC_AN_EN] = st.pctrl[ppcs_pkg::PC_AN_EN];
    basic_view[ppcs_pkg::BC_RESTART_AN] = st.pctrl[ppcs_pkg::PC_RESTART_AN];
    basic_view[ppcs_pkg::BC_DUPLEX] = st.pctrl[ppcs_pkg::PC_DUPLEX];
    basic_view[ppcs_pkg::BC_FORCE_X] = st.pctrl[ppcs_pkg::PC_FORCE_X];
    basic_view[ppcs_pkg::BC_NO_AUTOX] = st.pctrl[ppcs_pkg::PC_NO_AUTOX];
    basic_view[ppcs_pkg::BC_TX_DIS] = st.pctrl[ppcs_pkg::PC_TX_DIS];
    basic_view[ppcs_pkg::BC_LED_OFF] = st.pctrl[ppcs_pkg::PC_LED_OFF];
    status_view = {9'h000, an_done, link_good, partner_abil}; // [R02]
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pready = psel && penable && !st.pready;
    next_st.pslverr = 1'b0;
    next_st.diag_start = 1'b0;
    next_st.an_restart = 1'b0;
    next_st.an_done_q = an_done;
    next_st.link_q = link_good;
    hit = 1'b1;
    case (word_idx)
      {2'b00, ppcs_pkg::IDX_PARTNER}: next_st.prdata = {16'h0000, lpa_view};
      {2'b00, ppcs_pkg::IDX_DIAG}: next_st.prdata = {16'h0000, diag_view};
      {2'b00, ppcs_pkg::IDX_PORT_CTRL}: next_st.prdata = {16'h0000, st.pctrl};
      {2'b00, ppcs_pkg::IDX_BASIC_CTRL}: next_st.prdata = {16'h0000, basic_view};
      {2'b00, ppcs_pkg::IDX_PORT_STATUS}: next_st.prdata = {16'h0000, status_view};
      {2'b00, ppcs_pkg::IDX_INT_STATUS}: next_st.prdata = {29'h0, st.ists};
      {2'b00, ppcs_pkg::IDX_INT_MASK}: next_st.prdata = {29'h0, st.imask};
      default: begin
        next_st.prdata = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    if (!rd_acc) begin
      next_st.prdata = 32'h0000_0000;
    end
    if ((rd_acc || wr_acc) && !hit) begin
      next_st.pslverr = 1'b1;
    end
    // completion first; a start written in the same cycle is ignored [R04]
    if (diag_done && st.diag_en) begin
      next_st.diag_en = 1'b0;
      next_st.result = diag_result;
      next_st.count = diag_fault_count;
    end
    // restart is self-clearing after one cycle
    next_st.pctrl[ppcs_pkg::PC_RESTART_AN] = 1'b0;
    if (wr_acc && hit) begin
      case (word_idx)
        {2'b00, ppcs_pkg::IDX_DIAG}: begin
          if (pwdata[ppcs_pkg::DG_EN] && !st.diag_en) begin
            next_st.diag_en = 1'b1; // [R04]
            next_st.diag_start = 1'b1;
          end
          next_st.force_link = pwdata[ppcs_pkg::DG_FORCE_LINK]; // [R07]
          next_st.rloop = pwdata[ppcs_pkg::DG_RLOOP]; // [R08]
        end
        {2'b00, ppcs_pkg::IDX_PORT_CTRL}: begin
          // reserved bits 12,11,8 stay zero [R18]
          next_st.pctrl[ppcs_pkg::PC_LED_OFF] = pwdata[ppcs_pkg::PC_LED_OFF];
          next_st.pctrl[ppcs_pkg::PC_TX_DIS] = pwdata[ppcs_pkg::PC_TX_DIS];
          next_st.pctrl[ppcs_pkg::PC_RESTART_AN] = pwdata[ppcs_pkg::PC_RESTART_AN];
          next_st.pctrl[ppcs_pkg::PC_NO_AUTOX] = pwdata[ppcs_pkg::PC_NO_AUTOX];
          next_st.pctrl[ppcs_pkg::PC_FORCE_X] = pwdata[ppcs_pkg::PC_FORCE_X];
          next_st.pctrl[7:0] = pwdata[7:0];
        end
        {2'b00, ppcs_pkg::IDX_BASIC_CTRL}: begin
          next_st.pctrl[ppcs_pkg::PC_SPEED] = pwdata[ppcs_pkg::BC_SPEED]; // [R17]
          next_st.pctrl[ppcs_pkg::PC_AN_EN] = pwdata[ppcs_pkg::BC_AN_EN];
          next_st.pctrl[ppcs_pkg::PC_RESTART_AN] = pwdata[ppcs_pkg::BC_RESTART_AN];
          next_st.pctrl[ppcs_pkg::PC_DUPLEX] = pwdata[ppcs_pkg::BC_DUPLEX];
          next_st.pctrl[ppcs_pkg::PC_FORCE_X] = pwdata[ppcs_pkg::BC_FORCE_X];
          next_st.pctrl[ppcs_pkg::PC_NO_AUTOX] = pwdata[ppcs_pkg::BC_NO_AUTOX];
          next_st.pctrl[ppcs_pkg::PC_TX_DIS] = pwdata[ppcs_pkg::BC_TX_DIS];
          next_st.pctrl[ppcs_pkg::PC_LED_OFF] = pwdata[ppcs_pkg::BC_LED_OFF];
        end
        {2'b00, ppcs_pkg::IDX_INT_STATUS}: begin
          next_st.ists = st.ists & ~pwdata[ppcs_pkg::IRQ_W-1:0];
        end
        {2'b00, ppcs_pkg::IDX_INT_MASK}: begin
          next_st.imask = pwdata[ppcs_pkg::IRQ_W-1:0];
        end
        default: begin
          next_st.imask = st.imask;
        end
      endcase
    end
    // events applied after the clear so a same-cycle event survives
    if (diag_done && st.diag_en) begin
      next_st.ists[ppcs_pkg::IRQ_DIAG_DONE] = 1'b1;
    end
    if (an_done && !st.an_done_q) begin
      next_st.ists[ppcs_pkg::IRQ_AN_DONE] = 1'b1;
    end
    if (link_good != st.link_q) begin
      next_st.ists[ppcs_pkg::IRQ_LINK_CHG] = 1'b1;
    end
    next_st.irq = |(next_st.ists & next_st.imask);
    // outputs from the stored controls
    next_st.leds = next_st.pctrl[ppcs_pkg::PC_LED_OFF] ? 4'hf : led_in; // [R09]
    next_st.tx_disable = next_st.pctrl[ppcs_pkg::PC_TX_DIS]; // [R10]
    next_st.an_restart = next_st.pctrl[ppcs_pkg::PC_RESTART_AN]; // [R11]
    next_st.an_enable = next_st.pctrl[ppcs_pkg::PC_AN_EN]; // [R14]
    next_st.auto_cross_en = !next_st.pctrl[ppcs_pkg::PC_NO_AUTOX]; // [R12]
    next_st.force_cross = next_st.pctrl[ppcs_pkg::PC_NO_AUTOX] && next_st.pctrl[ppcs_pkg::PC_FORCE_X]; // [R13]
    next_st.speed_100 = next_st.pctrl[ppcs_pkg::PC_SPEED]; // [R15]
    next_st.full_duplex = next_st.pctrl[ppcs_pkg::PC_DUPLEX]; // [R16]
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.pctrl <= ppcs_pkg::PC_RESET; // [R14]
      st.imask <= ppcs_pkg::MASK_RESET;
      st.leds <= 4'h0;
      st.an_enable <= 1'b1;
      st.auto_cross_en <= 1'b1;
      st.speed_100 <= 1'b1;
      st.full_duplex <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign port_led_out = st.leds;
  assign diag_start = st.diag_start;
  assign force_link = st.force_link;
  assign remote_loop = st.rloop;
  assign tx_disable = st.tx_disable;
  assign an_restart = st.an_restart;
  assign an_enable = st.an_enable;
  assign auto_cross_en = st.auto_cross_en;
  assign force_cross = st.force_cross;
  assign speed_100 = st.speed_100;
  assign full_duplex = st.full_duplex;
  assign irq = st.irq;
endmodule : ppcs_regs

// *** ppcs_pkg.sv ***
package ppcs_pkg;
  // register indexes; the bus byte address is four times the index
  localparam logic [7:0] IDX_PARTNER = 8'hee;
  localparam logic [7:0] IDX_DIAG = 8'hf4;
  localparam logic [7:0] IDX_PORT_CTRL = 8'hf6;
  localparam logic [7:0] IDX_BASIC_CTRL = 8'he4;
  localparam logic [7:0] IDX_PORT_STATUS = 8'hf8;
  localparam logic [7:0] IDX_INT_STATUS = 8'hfc;
  localparam logic [7:0] IDX_INT_MASK = 8'hfd;
  // partner ability bits
  localparam int LPA_PAUSE = 10;
  localparam int LPA_100F = 8;
  localparam int LPA_100H = 7;
  localparam int LPA_10F = 6;
  localparam int LPA_10H = 5;
  localparam logic [4:0] LPA_SELECTOR = 5'h01;
  // diag register fields
  localparam int DG_RES_HI = 14;
  localparam int DG_RES_LO = 13;
  localparam int DG_EN = 12;
  localparam int DG_FORCE_LINK = 11;
  localparam int DG_RLOOP = 9;
  localparam int DG_CNT_HI = 8;
  // port control fields
  localparam int PC_LED_OFF = 15;
  localparam int PC_TX_DIS = 14;
  localparam int PC_RESTART_AN = 13;
  localparam int PC_NO_AUTOX = 10;
  localparam int PC_FORCE_X = 9;
  localparam int PC_AN_EN = 7;
  localparam int PC_SPEED = 6;
  localparam int PC_DUPLEX = 5;
  // basic control positions of the shared bits
  localparam int BC_SPEED = 13;
  localparam int BC_AN_EN = 12;
  localparam int BC_RESTART_AN = 9;
  localparam int BC_DUPLEX = 8;
  localparam int BC_FORCE_X = 4;
  localparam int BC_NO_AUTOX = 3;
  localparam int BC_TX_DIS = 1;
  localparam int BC_LED_OFF = 0;
  // interrupt status bits
  localparam int IRQ_DIAG_DONE = 0;
  localparam int IRQ_AN_DONE = 1;
  localparam int IRQ_LINK_CHG = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [15:0] PC_RESET = 16'h00ff;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
endpackage : ppcs_pkg

// *** ppcs_regs_properties.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// register bank checker
// ----------------------------------------
module ppcs_regs_properties (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic diag_start, // cable test start pulse
  input wire logic diag_done, // cable test finished pulse
  input wire logic tx_disable, // transmitter off
  input wire logic an_restart, // negotiation restart pulse
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic [4:0] partner_abil, // partner abilities
  input wire logic [3:0] port_led_out // led pins
);
  wire wpc = pready && pwrite && paddr == 12'h3d8;
  // a start written while a test runs is ignored, so track the running test
  logic busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else if (diag_start) begin
      busy <= 1'b1;
    end else if (diag_done) begin
      busy <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_delay: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access edge");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_unmapped_err: assert property (pready && paddr == 12'h3c0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_partner_bits: assert property (pready && !pwrite && paddr == 12'h3b8 |->
    prdata == {21'h0, partner_abil[4], 1'b0, partner_abil[3:0], 5'h01})
    else $error("partner ability layout wrong");
  a_led_off: assert property (wpc && pwdata[15] |-> ##[1:3] port_led_out == 4'hf)
    else $error("leds not driven high");
  a_tx_off: assert property (wpc && pwdata[14] |-> ##[1:3] tx_disable)
    else $error("transmitter not disabled");
  a_restart_pulse: assert property (wpc && pwdata[13] |-> an_restart ##1 !an_restart)
    else $error("restart pulse missing or long");
  a_diag_start: assert property (pready && pwrite && paddr == 12'h3d0 && pwdata[12] && !$past(busy) |->
    diag_start ##1 !diag_start)
    else $error("cable test start pulse wrong");
endmodule : ppcs_regs_properties
bind ppcs_regs ppcs_regs_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .diag_start, .diag_done, .tx_disable, .an_restart, .paddr, .pwdata, .prdata, .partner_abil, .port_led_out);

// *** ppcs_phy_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// transceiver cable test model
// ----------------------------------------
module ppcs_phy_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic diag_start, // test request
  input wire logic [1:0] res_cfg, // outcome of next test
  input wire logic [8:0] cnt_cfg, // fault count of next test
  output logic diag_done, // test finished pulse
  output logic [1:0] diag_result, // outcome
  output logic [8:0] diag_fault_count // fault count
);
  logic [4:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 5'h0;
      diag_done <= 1'b0;
      diag_result <= 2'h0;
      diag_fault_count <= 9'h0;
    end else begin
      diag_done <= cnt == 5'h1;
      if (diag_start) cnt <= 5'hc;
      else if (cnt != 5'h0) cnt <= cnt - 5'h1;
      // results only valid with the pulse, so scramble them otherwise
      diag_result <= (cnt == 5'h1) ? res_cfg : ~diag_result;
      diag_fault_count <= (cnt == 5'h1) ? cnt_cfg : ~diag_fault_count;
    end
  end
endmodule : ppcs_phy_model

// *** test_phy_port_ctrl_status_regs.sv ***
`timescale 1ns/100ps
module test_phy_port_ctrl_status_regs;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, diag_done, diag_start, force_link, remote_loop, tx_disable, an_restart;
  logic an_enable, auto_cross_en, force_cross, speed_100, full_duplex, irq;
  logic [4:0] partner_abil = 5'h15;
  logic [1:0] diag_result, res_cfg = 2'h0;
  logic [8:0] diag_fault_count, cnt_cfg = 9'h0;
  logic [3:0] led_in = 4'h5, port_led_out;
  logic an_done = 1'b0, link_good = 1'b0;
  int fails = 0, checks = 0, cyc = 0, n;
  ppcs_regs i_ppcs_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .partner_abil, .an_done, .an_failed(1'b0), .link_good, .diag_done, .diag_result,
    .diag_fault_count, .led_in, .port_led_out, .diag_start, .force_link, .remote_loop, .tx_disable,
    .an_restart, .an_enable, .auto_cross_en, .force_cross, .speed_100, .full_duplex, .irq);
  ppcs_phy_model i_ppcs_phy_model (.pclk, .presetn, .diag_start, .res_cfg, .cnt_cfg, .diag_done,
    .diag_result, .diag_fault_count);
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(q & m, x);
  endtask : rd
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h3d8, 32'hffff, {16'h0, ppcs_pkg::PC_RESET});
    chk({an_enable, auto_cross_en, speed_100, full_duplex}, 4'hf);
    rd(12'h3d0, 32'hffff, 32'h0);
    apb(12'h3c0, 1'b0, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      partner_abil <= i ? 5'h0a : 5'h15;
      wr(12'h3b8, 32'hffff);
      rd(12'h3b8, 32'hffffffff, {21'h0, partner_abil[4], 1'b0, partner_abil[3:0], 5'h01});
      rd(12'h3e0, 32'h1f, {27'h0, partner_abil});
    end
    $display("test partner done");
    an_done <= 1'b1;
    link_good <= 1'b1;
    rd(12'h3e0, 32'h60, 32'h60);
    rd(12'h3f0, 32'h7, 32'h6);
    wr(12'h3f4, 32'h6);
    rd(12'h3f4, 32'h7, 32'h6);
    chk(irq, 1'b1);
    wr(12'h3f0, 32'h6);
    rd(12'h3f0, 32'h7, 32'h0);
    chk(irq, 1'b0);
    $display("test interrupt done");
    wr(12'h3d8, 32'hdf00);
    rd(12'h3d8, 32'hffe0, 32'hc600);
    chk({port_led_out, tx_disable, auto_cross_en, force_cross, an_enable, speed_100, full_duplex},
      10'h3e8);
    wr(12'h3d8, 32'h2060);
    rd(12'h3d8, 32'hffe0, 32'h0060);
    chk({port_led_out, tx_disable, auto_cross_en, an_enable, speed_100, full_duplex}, 9'h0ab);
    wr(12'h390, 32'h1001);
    rd(12'h3d8, 32'hffe0, 32'h8080);
    $display("test port control done");
    for (int c = 0; c < 4; c++) begin
      wr(12'h3f4, {31'h0, c[0]});
      chk(irq, 1'b0);
      res_cfg <= c[1:0];
      cnt_cfg <= 9'h0a5 + 9'(c);
      wr(12'h3d0, 32'h1a00);
      rd(12'h3d0, 32'h1000, 32'h1000);
      chk({force_link, remote_loop}, 2'h3);
      do apb(12'h3d0, 1'b0, 32'h0); while (q[12] !== 1'b0 && cyc < 4000);
      chk(q & 32'hffff, 32'(c << 13) | 32'h0a00 | (32'h0a5 + 32'(c)));
      chk(irq, c[0]);
      rd(12'h3f0, 32'h1, 32'h1);
      wr(12'h3f0, 32'h1);
    end
    $display("test cable diagnostic done");
    test_done();
  end
endmodule : test_phy_port_ctrl_status_regs
